// ---- include/mmc_defines.svh ----
/*
 * Constants for the mode latch and memory map configuration block.
 * Assumes a 100 MHz pclk and word-aligned APB access.
 */
// Contract
// RQ1 - mode pin b high at reset selects normal mode, vector $FFFA
// RQ2 - mode pin b low at reset selects special mode, vector $BFFA
// RQ3 - pins b,a latch boot/special/expand: 10=000 11=001 00=110 01=011
// RQ4 - boot, special and expand flags are writable only while special is 1
// RQ5 - boot rom enable decodes boot rom at $BE40-$BFFF, else absent
// RQ6 - special flag once cleared cannot be set until next reset
// RQ7 - expand flag 1 enables external buses, 0 leaves pins as ports
// RQ8 - protected bits: first 64 cycles or once per reset; special bypasses
// RQ9 - setup register latched from nonvolatile cells at reset drives device
// RQ10 - setup register bits 6 and 5 always read one
// RQ11 - setup register writable directly only while special flag is 1
// RQ12 - rom placement 1 maps rom high, 0 low when expanded; single chip sets
// RQ13 - pull-up register enable gates pull-up assignment and all pull-ups
// RQ14 - watchdog disable 0 enables watchdog; security disable 1 turns off
// RQ15 - rom enable maps rom; reset sets in single chip, clears in test
// RQ16 - nvm enable includes the on-chip eeprom in the map
// RQ17 - ram and register map register: one write in first 64 cycles
// RQ18 - ram page field gives top digit; 1 KB ram at page start
// RQ19 - register page field gives top digit; 128-byte block at page start
// RQ20 - register block wins overlap, ram moves just after it
// RQ21 - nvm page bits 7-4 written once in normal modes, 3-0 any time
// RQ22 - nvm page field gives top digit; eeprom at $xD80-$xFFF
// RQ23 - after reset release mode pins are ignored until next reset
// RQ24 - write to protected bit outside its window changes nothing
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH
// register indexes, byte address is four times the index
`define MMC_IDX_NVM_PAGE 6'h37
`define MMC_IDX_MODE 6'h3c
`define MMC_IDX_INIT 6'h3d
`define MMC_IDX_SETUP 6'h3f
// reset values
`define MMC_RST_INIT 8'h00
`define MMC_RST_NVM_PAGE 8'h00
// setup register fixed-one bits 6:5
`define MMC_SETUP_ONES 2'h3
// timing
`define MMC_WIN_CYCLES 7'h40
`define MMC_SYNC_CYCLES 7'h03
// memory map
`define MMC_VEC_NORMAL 16'hfffa
`define MMC_VEC_SPECIAL 16'hbffa
`define MMC_BOOT_LO 16'hbe40
`define MMC_BOOT_HI 16'hbfff
`define MMC_RAM_SIZE 12'h400
`define MMC_REG_SIZE 12'h080
`define MMC_NVM_LO 12'hd80
`endif

// ---- include/mmc_pkg.sv ----
/*
 * Types for the mode latch and memory map configuration block.
 * Assumes mmc_defines.svh holds the register, reset, timing and memory map constants.
 */
package mmc_pkg;
    // latched operating mode flags
    typedef struct packed {
        logic boot_rom_enable;
        logic special_mode_flag;
        logic bus_expand_flag;
    } mmc_mode_s;
    // setup latch fields, bits 7 and 4:0 of the register
    typedef struct packed {
        logic rom_placement;
        logic pullup_register_enable;
        logic security_disable;
        logic watchdog_disable;
        logic rom_enable;
        logic nvm_enable;
    } mmc_setup_s;
    // decoded region selects
    typedef struct packed {
        logic regs;
        logic ram;
        logic boot;
        logic nvm;
        logic rom;
    } mmc_sel_s;
    typedef enum logic [1:0] {
        MMC_ST_SYNC = 2'b01,
        MMC_ST_RUN = 2'b10
    } mmc_state_e;
endpackage : mmc_pkg

// ---- rtl/mmc_top.sv ----
/*
 * Mode latch, protected configuration registers and memory map
 * decode, reached over APB.
 * Assumes mode pins and nonvolatile cells are stable around reset;
 * cpu_addr comes from logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defines.svh"
module mmc_top
    import mmc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap pins and nonvolatile cells
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic [7:0] nvm_cells,
    // cpu address to decode
    input wire logic [15:0] cpu_addr,
    // mode and configuration state
    output mmc_mode_s mode,
    output mmc_setup_s setup,
    output logic watchdog_enable,
    output logic [15:0] reset_vector,
    output logic [7:0] ram_reg_map,
    output logic [7:0] nvm_page_map,
    output logic config_ready,
    // decode results, one cycle after cpu_addr
    output mmc_sel_s sel,
    output logic [9:0] ram_index
);

    mmc_state_e st_ff;
    logic [9:0] sy1_ff;
    logic [9:0] sy2_ff;
    logic [9:0] sy3_ff;
    logic [6:0] cnt_ff;
    mmc_mode_s mode_ff;
    mmc_setup_s setup_ff;
    logic [7:0] init_ff;
    logic init_done_ff;
    logic [7:0] nvm_pg_ff;
    logic nvm_pg_done_ff;
    logic [15:0] vec_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    mmc_sel_s sel_ff;
    logic [9:0] ram_idx_ff;
    logic wdog_ff;

    logic cap;
    logic win;
    logic setup_ph;
    logic acc;
    logic wr;
    logic [5:0] idx;
    logic hit;
    logic [7:0] wd;
    logic [7:0] rd;
    mmc_mode_s nxt_mode;
    mmc_setup_s nxt_setup;

    // three-stage synchroniser for straps and cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_ff <= 10'h000;
            sy2_ff <= 10'h000;
            sy3_ff <= 10'h000;
        end else begin
            sy1_ff <= {mode_pin_b, mode_pin_a, nvm_cells};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
        end
    end

    // capture once the chain has filled and stages two and three agree
    assign cap = (st_ff == MMC_ST_SYNC) && (cnt_ff >= `MMC_SYNC_CYCLES)
        && (sy2_ff == sy3_ff);

    // 64-cycle protection window, counted from reset release
    assign win = cnt_ff < `MMC_WIN_CYCLES; // [RQ8] [RQ17]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 7'h00;
        end else if (cnt_ff < `MMC_WIN_CYCLES) begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end

    // sync then run; pins never looked at again once running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= MMC_ST_SYNC;
        end else begin
            case (st_ff)
                MMC_ST_SYNC: begin
                    if (cap) begin
                        st_ff <= MMC_ST_RUN; // [RQ23]
                    end
                end
                MMC_ST_RUN: begin
                    st_ff <= MMC_ST_RUN;
                end
                default: begin
                    st_ff <= MMC_ST_SYNC;
                end
            endcase
        end
    end

    // apb decode
    assign setup_ph = psel && !penable;
    assign acc = psel && penable && pready_ff;
    assign idx = paddr[7:2];
    assign hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00)
        && (idx == `MMC_IDX_NVM_PAGE || idx == `MMC_IDX_MODE
        || idx == `MMC_IDX_INIT || idx == `MMC_IDX_SETUP);
    // only lane 0 carries the byte-wide registers
    assign wr = acc && pwrite && pstrb[0] && !pslverr_ff;
    assign wd = pwdata[7:0];

    // read mux
    always_comb begin
        rd = 8'h00;
        case (idx)
            `MMC_IDX_MODE: rd = {mode_ff, 5'h00};
            `MMC_IDX_INIT: rd = init_ff;
            `MMC_IDX_NVM_PAGE: rd = nvm_pg_ff;
            `MMC_IDX_SETUP: begin
                rd = {setup_ff.rom_placement, `MMC_SETUP_ONES,
                    setup_ff[4:0]}; // [RQ9] [RQ10]
            end
            default: rd = 8'h00;
        endcase
    end

    // zero-wait answer: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_ph;
            if (setup_ph) begin
                // refuse everything until the straps are latched
                pslverr_ff <= !hit || (st_ff != MMC_ST_RUN);
                prdata_ff <= hit ? {24'h000000, rd} : 32'h0000_0000;
            end
        end
    end

    // mode flags from the straps; later writes only in special mode
    always_comb begin
        nxt_mode = mode_ff;
        if (cap) begin
            case (sy3_ff[9:8])
                2'b10: nxt_mode = 3'b000; // [RQ3]
                2'b11: nxt_mode = 3'b001; // [RQ3]
                2'b00: nxt_mode = 3'b110; // [RQ3]
                2'b01: nxt_mode = 3'b011; // [RQ3]
                default: nxt_mode = 3'b000;
            endcase
        end else if (wr && idx == `MMC_IDX_MODE
                && mode_ff.special_mode_flag) begin // [RQ4] [RQ24]
            nxt_mode.boot_rom_enable = wd[7];
            // a cleared flag stays cleared
            nxt_mode.special_mode_flag = wd[6]; // [RQ6]
            nxt_mode.bus_expand_flag = wd[5]; // [RQ7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= 3'b000;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // vector area chosen by the strapped special flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_ff <= `MMC_VEC_NORMAL;
        end else if (cap) begin
            vec_ff <= sy3_ff[9] ? `MMC_VEC_NORMAL // [RQ1]
                : `MMC_VEC_SPECIAL; // [RQ2]
        end
    end

    // setup latch: loaded from cells, rom bits forced by mode
    always_comb begin
        nxt_setup = setup_ff;
        if (cap) begin
            nxt_setup = {sy3_ff[7], sy3_ff[4:0]}; // [RQ9]
            if (nxt_mode == 3'b000) begin
                nxt_setup.rom_placement = 1'b1; // [RQ12]
                nxt_setup.rom_enable = 1'b1; // [RQ15]
            end else if (nxt_mode == 3'b011) begin
                nxt_setup.rom_enable = 1'b0; // [RQ15]
            end
        end else if (wr && idx == `MMC_IDX_SETUP
                && mode_ff.special_mode_flag) begin // [RQ11] [RQ24]
            nxt_setup = {wd[7], wd[4:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_ff <= 6'h00;
        end else begin
            setup_ff <= nxt_setup;
        end
    end

    // ram and register page: one write inside the window, any write while special
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_ff <= `MMC_RST_INIT;
            init_done_ff <= 1'b0;
        end else if (wr && idx == `MMC_IDX_INIT) begin
            if (mode_ff.special_mode_flag
                    || (win && !init_done_ff)) begin // [RQ17] [RQ8]
                init_ff <= wd;
                init_done_ff <= 1'b1;
            end
        end
    end

    // nvm page high nibble once in normal modes; low nibble free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_pg_ff <= `MMC_RST_NVM_PAGE;
            nvm_pg_done_ff <= 1'b0;
        end else if (wr && idx == `MMC_IDX_NVM_PAGE) begin
            nvm_pg_ff[3:0] <= wd[3:0]; // [RQ21]
            if (mode_ff.special_mode_flag || !nvm_pg_done_ff) begin
                nvm_pg_ff[7:4] <= wd[7:4]; // [RQ21] [RQ24]
                nvm_pg_done_ff <= 1'b1;
            end
        end
    end

    // region decode, registered; registers first, then ram, boot,
    // nvm, rom. ram offset is relative to its moved base.
    logic [11:0] off;
    logic [11:0] ram_off;
    logic same_pg;
    logic reg_hit;
    logic ram_hit;
    logic boot_hit;
    logic nvm_hit;
    logic rom_hit;
    assign off = cpu_addr[11:0];
    assign same_pg = init_ff[7:4] == init_ff[3:0];
    assign reg_hit = cpu_addr[15:12] == init_ff[3:0]
        && off < `MMC_REG_SIZE; // [RQ19]
    assign ram_off = same_pg ? off - `MMC_REG_SIZE : off; // [RQ20]
    assign ram_hit = cpu_addr[15:12] == init_ff[7:4] && !reg_hit
        && (!same_pg || off >= `MMC_REG_SIZE)
        && ram_off < `MMC_RAM_SIZE; // [RQ18] [RQ20]
    assign boot_hit = mode_ff.boot_rom_enable
        && cpu_addr >= `MMC_BOOT_LO
        && cpu_addr <= `MMC_BOOT_HI; // [RQ5]
    assign nvm_hit = setup_ff.nvm_enable
        && cpu_addr[15:12] == nvm_pg_ff[7:4]
        && off >= `MMC_NVM_LO; // [RQ16] [RQ22]
    // low-half rom exists only on an expanded bus
    assign rom_hit = setup_ff.rom_enable
        && (setup_ff.rom_placement || !mode_ff.bus_expand_flag
        ? cpu_addr[15] : !cpu_addr[15]); // [RQ12] [RQ15]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= 5'h00;
            ram_idx_ff <= 10'h000;
        end else if (st_ff == MMC_ST_RUN) begin
            sel_ff.regs <= reg_hit;
            sel_ff.ram <= ram_hit;
            sel_ff.boot <= boot_hit && !reg_hit && !ram_hit;
            sel_ff.nvm <= nvm_hit && !reg_hit && !ram_hit
                && !boot_hit;
            sel_ff.rom <= rom_hit && !reg_hit && !ram_hit
                && !boot_hit && !nvm_hit;
            ram_idx_ff <= ram_off[9:0];
        end
    end

    // watchdog runs unless disabled in the setup latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_ff <= 1'b0;
        end else begin
            wdog_ff <= (st_ff == MMC_ST_RUN)
                && !setup_ff.watchdog_disable; // [RQ14]
        end
    end

    // outputs, each straight from a flop
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mode = mode_ff;
    assign setup = setup_ff; // [RQ13] [RQ14]
    assign watchdog_enable = wdog_ff;
    assign reset_vector = vec_ff;
    assign ram_reg_map = init_ff;
    assign nvm_page_map = nvm_pg_ff;
    assign config_ready = st_ff[1];
    assign sel = sel_ff;
    assign ram_index = ram_idx_ff;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_VEC_NORMAL: assert property ( // [RQ1]
        $rose(st_ff == MMC_ST_RUN)
            && !mode_ff.special_mode_flag
            |-> vec_ff == `MMC_VEC_NORMAL)
        else $error("normal vector wrong");

    AST_VEC_SPECIAL: assert property ( // [RQ2]
        $rose(st_ff == MMC_ST_RUN) && mode_ff.special_mode_flag
            |-> vec_ff == `MMC_VEC_SPECIAL)
        else $error("special vector wrong");

    AST_STRAP: assert property ( // [RQ3]
        cap && sy3_ff[9:8] == 2'b00 |=> mode_ff == 3'b110)
        else $error("bootstrap mode not latched");

    AST_MODE_LOCK: assert property ( // [RQ4]
        st_ff == MMC_ST_RUN && !mode_ff.special_mode_flag
            |=> $stable(mode_ff))
        else $error("mode changed in normal mode");

    AST_NO_RESET_SPECIAL_MODE_FLAG: assert property ( // [RQ6]
        st_ff == MMC_ST_RUN && !mode_ff.special_mode_flag
            |=> !mode_ff.special_mode_flag)
        else $error("special flag set again");

    AST_SETUP_READ: assert property ( // [RQ10]
        setup_ph && hit && idx == `MMC_IDX_SETUP
            |=> prdata_ff[6:5] == 2'b11)
        else $error("setup bits 6:5 not one");

    AST_INIT_LATE: assert property ( // [RQ17]
        wr && idx == `MMC_IDX_INIT && !win
            && !mode_ff.special_mode_flag |=> $stable(init_ff))
        else $error("late map write took effect");

    AST_NVM_ONCE: assert property ( // [RQ21]
        wr && idx == `MMC_IDX_NVM_PAGE && nvm_pg_done_ff
            && !mode_ff.special_mode_flag
            |=> $stable(nvm_pg_ff[7:4])
            && nvm_pg_ff[3:0] == $past(wd[3:0]))
        else $error("nvm page write protection wrong");

    AST_REG_WINS: assert property ( // [RQ20]
        sel_ff.regs |-> !sel_ff.ram)
        else $error("ram and registers both selected");

    AST_BOOT_RANGE: assert property ( // [RQ5]
        sel_ff.boot |-> $past(cpu_addr) >= `MMC_BOOT_LO
            && $past(mode_ff.boot_rom_enable))
        else $error("boot rom decoded out of range");

endmodule : mmc_top
`default_nettype wire

// ---- sim/test_mmc_top.sv ----
/*
 * Self-checking bench for mmc_top: straps in all four modes, protected
 * register windows, setup latch and the memory map decode.
 * Assumes zero-wait APB answers and a one-cycle decode lag.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defines.svh"
module test_mmc_top
    import mmc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, m;
    logic [3:0] pstrb, rampg, regp, nvpg, p;
    logic mode_pin_a, mode_pin_b, config_ready, watchdog_enable, sgo;
    logic [7:0] nvm_cells, w;
    logic [15:0] cpu_addr, reset_vector, vec;
    logic [16:0] e;
    logic [53:0] se;
    logic [7:0] ram_reg_map, nvm_page_map;
    logic [9:0] ram_index;
    logic [15:0] ta [9];
    mmc_mode_s mode, em;
    mmc_setup_s setup, es;
    mmc_sel_s sel;
    logic [16:0] aq [$];
    logic [53:0] sq [$];
    int fail_count, num_checks;
    mmc_mode_s mtab [4] = '{3'b000, 3'b001, 3'b110, 3'b011};
    logic [1:0] ptab [4] = '{2'b10, 2'b11, 2'b00, 2'b01};

    mmc_top mmc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_pin_a(mode_pin_a),
        .mode_pin_b(mode_pin_b), .nvm_cells(nvm_cells),
        .cpu_addr(cpu_addr), .mode(mode), .setup(setup),
        .watchdog_enable(watchdog_enable), .reset_vector(reset_vector),
        .ram_reg_map(ram_reg_map), .nvm_page_map(nvm_page_map),
        .config_ready(config_ready), .sel(sel), .ram_index(ram_index));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // setup register as read back: bits 6:5 fixed at one
    function automatic logic [7:0] sreg();
        return {es[5], `MMC_SETUP_ONES, es[4:0]};
    endfunction : sreg

    // expected region select, priority regs > ram > boot > nvm > rom
    function automatic mmc_sel_s exp_sel(input logic [15:0] a);
        logic [15:0] rb;
        mmc_sel_s s;
        rb = {rampg, 12'h000} + ((rampg == regp) ? 16'h0080 : 16'h0000);
        s = '0;
        s.regs = (a[15:12] == regp) && (a[11:0] < `MMC_REG_SIZE);
        s.ram = !s.regs && a >= rb && (a - rb) < {4'h0, `MMC_RAM_SIZE};
        s.boot = !s.regs && !s.ram && em.boot_rom_enable &&
            a >= `MMC_BOOT_LO && a <= `MMC_BOOT_HI;
        s.nvm = !s.regs && !s.ram && !s.boot && es.nvm_enable &&
            a[15:12] == nvpg && a[11:0] >= `MMC_NVM_LO;
        s.rom = !s.regs && !s.ram && !s.boot && !s.nvm && es.rom_enable &&
            ((es.rom_placement || !em.bus_expand_flag) ? a[15] : !a[15]);
        return s;
    endfunction : exp_sel

    task report_and_stop;
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task tmo;
        $display("BAD %0t wait ran out", $time);
        fail_count++;
        report_and_stop;
    endtask : tmo

    // one apb transfer; d is write data or expected read data
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] d, input logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00, 4'h0} >> 4;
        pwdata <= {rnd[31:8] & {24{wr}}, d};
        aq.push_back({(wr || er) ? 8'h00 : 8'hff, er, d});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            tmo();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // drive a cpu address and note the expected level outputs
    task automatic stat(input logic [15:0] a);
        logic [15:0] rb;
        mmc_sel_s s;
        @(posedge pclk);
        cpu_addr <= a;
        s = exp_sel(a);
        // ram byte offset from its base, moved past the registers on overlap
        rb = {rampg, 12'h000} + ((rampg == regp) ? 16'h0080 : 16'h0000);
        rb = a - rb;
        sq.push_back({s, vec, ~es.watchdog_disable, em, es, rampg, regp,
            nvpg, s.ram, rb[9:0]});
        @(posedge pclk);
        sgo <= 1'b1;
        @(posedge pclk);
        sgo <= 1'b0;
    endtask : stat

    // reset with given straps; pins and cells move once captured
    task automatic rst(input logic [1:0] ba, input mmc_mode_s mm);
        int n;
        rnd = lfsr(rnd);
        @(posedge pclk);
        presetn <= 1'b0;
        {mode_pin_b, mode_pin_a} <= ba;
        nvm_cells <= rnd[7:0];
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        while (config_ready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            tmo();
        {mode_pin_b, mode_pin_a} <= ~ba;
        nvm_cells <= ~rnd[7:0];
        em = mm;
        vec = mm.special_mode_flag ? `MMC_VEC_SPECIAL : `MMC_VEC_NORMAL;
        es = {rnd[7], rnd[4:0]};
        if (ba == 2'b10) begin
            es.rom_placement = 1'b1;
            es.rom_enable = 1'b1;
        end
        if (ba == 2'b01)
            es.rom_enable = 1'b0;
        rampg = 4'h0;
        regp = 4'h0;
        nvpg = 4'h0;
    endtask : rst

    // apb results, compared at the completing edge
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = aq.pop_front();
            m = (e[16:9] == 8'hff) ? 32'hffffffff : 32'h0;
            num_checks++;
            if (pslverr !== e[8] || (prdata & m) !== ({24'h0, e[7:0]} & m))
            begin
                $display("BAD %0t apb got %h exp %h", $time, prdata, e);
                fail_count++;
            end
        end
    end

    // level outputs, sampled mid-cycle once settled
    always @(negedge pclk) begin
        if (sgo) begin
            se = sq.pop_front();
            num_checks++;
            if ({sel, reset_vector, watchdog_enable, mode, setup,
                ram_reg_map, nvm_page_map[7:4]} !== se[53:11]
                || (se[10] && ram_index !== se[9:0]))
            begin
                $display("BAD %0t status exp %h", $time, se);
                fail_count++;
            end
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        tmo();
    end

    initial begin
        {presetn, psel, penable, pwrite, sgo, mode_pin_a} = '0;
        {paddr, pwdata, cpu_addr, mode_pin_b, nvm_cells} = '0;
        pstrb = 4'hf;
        rnd = 32'hb61d2a2e;
        fail_count = 0;
        num_checks = 0;
        for (int i = 0; i < 4; i++) begin
            rst(ptab[i], mtab[i]);
            apb(0, `MMC_IDX_MODE, {em, 5'h00}, 0);
            apb(0, `MMC_IDX_SETUP, sreg(), 0);
            apb(0, `MMC_IDX_INIT, `MMC_RST_INIT, 0);
            apb(0, `MMC_IDX_NVM_PAGE, `MMC_RST_NVM_PAGE, 0);
            stat(16'hbe40);
            stat(16'h0d80);
            if (i == 0) begin
                apb(1, `MMC_IDX_MODE, 8'he0, 0);
                apb(0, `MMC_IDX_MODE, 8'h00, 0);
                apb(1, `MMC_IDX_SETUP, ~sreg(), 0);
                apb(0, `MMC_IDX_SETUP, sreg(), 0);
                rnd = lfsr(rnd);
                p = rnd[3:0];
                apb(1, `MMC_IDX_INIT, {p, p}, 0);
                apb(1, `MMC_IDX_INIT, ~{p, p}, 0);
                apb(0, `MMC_IDX_INIT, {p, p}, 0);
                rampg = p;
                regp = p;
                apb(1, `MMC_IDX_NVM_PAGE, rnd[15:8], 0);
                apb(1, `MMC_IDX_NVM_PAGE, {~rnd[15:12], rnd[7:4]}, 0);
                apb(0, `MMC_IDX_NVM_PAGE, {rnd[15:12], rnd[7:4]}, 0);
                nvpg = rnd[15:12];
                apb(0, 6'h10, 8'h00, 1);
                apb(1, 6'h10, 8'h00, 1);
                ta = '{{p, 12'h000}, {p, 12'h07f}, {p, 12'h080},
                    {p, 12'h47f}, {p, 12'h480}, {nvpg, 12'hd80},
                    {nvpg, 12'hd7f}, 16'h8000, 16'h7fff};
                foreach (ta[k])
                    stat(ta[k]);
            end
            if (i == 1) begin
                repeat (70) @(posedge pclk);
                apb(1, `MMC_IDX_INIT, 8'h12, 0);
                apb(0, `MMC_IDX_INIT, 8'h00, 0);
                apb(1, `MMC_IDX_NVM_PAGE, 8'h90, 0);
                apb(0, `MMC_IDX_NVM_PAGE, 8'h90, 0);
                nvpg = 4'h9;
                stat(16'h9d80);
                stat(16'h7fff);
                stat(16'h8000);
            end
            if (i == 2) begin
                apb(1, `MMC_IDX_INIT, 8'h31, 0);
                apb(1, `MMC_IDX_INIT, 8'h42, 0);
                apb(0, `MMC_IDX_INIT, 8'h42, 0);
                rampg = 4'h4;
                regp = 4'h2;
                apb(1, `MMC_IDX_NVM_PAGE, 8'h70, 0);
                apb(1, `MMC_IDX_NVM_PAGE, 8'hc0, 0);
                apb(0, `MMC_IDX_NVM_PAGE, 8'hc0, 0);
                nvpg = 4'hc;
                w = rnd[23:16];
                apb(1, `MMC_IDX_SETUP, w, 0);
                es = {w[7], w[4:0]};
                apb(0, `MMC_IDX_SETUP, sreg(), 0);
                ta = '{16'h4000, 16'h43ff, 16'h4400, 16'h2000, 16'h207f,
                    16'hbe3f, 16'hbfff, 16'hcd80, 16'hcfff};
                foreach (ta[k])
                    stat(ta[k]);
                apb(1, `MMC_IDX_MODE, 8'h20, 0);
                apb(1, `MMC_IDX_MODE, 8'h40, 0);
                apb(0, `MMC_IDX_MODE, 8'h20, 0);
            end
        end
        report_and_stop;
    end
endmodule : test_mmc_top
`default_nettype wire
